/* File: cdlt_pkg.sv */
// constants for the codec dac load timing block
package cdlt_pkg;
    localparam int          WORD_BITS        = 16;
    localparam int          CLK_SYS_NS       = 40;
    localparam int          SAMPLE_PERIOD_NS = 125000;
    localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_SYS_NS;
    localparam int          ADV_STEP_NS      = 1000;
    localparam int          ADV_STEP_CYCLES  = ADV_STEP_NS / CLK_SYS_NS;
    localparam int          ADV_BITS         = 4;
    localparam int          FIFO_DEPTH       = 16;
    localparam int          CTRL_FLAG_BIT    = 15;
    localparam int          READBACK_BIT     = 14;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    localparam logic [15:0] DAC_RESET        = 16'h0000;
    localparam logic [1:0]  READBACK_TAG     = 2'h3;
    typedef enum logic {CDLT_TX_IDLE, CDLT_TX_SHIFT} cdlt_tx_state_t;
endpackage

/* File: cdlt_codec_dac_load_timing.sv */
// adc word fifo, serial link and dac load timing of the codec block
`timescale 1ns/1ns

module cdlt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    always_comb
    begin
        push        = i_in_valid && o_in_ready;
        pop         = o_out_valid && i_out_ready;
        next_wr_ptr = push ? AW'((32'(wr_ptr) + 1) % DEPTH) : wr_ptr;
        next_rd_ptr = pop ? AW'((32'(rd_ptr) + 1) % DEPTH) : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            count      <= '0;
            o_in_ready <= 1'b1;
        end
        else
        begin
            wr_ptr     <= next_wr_ptr;
            rd_ptr     <= next_rd_ptr;
            count      <= next_count;
            // registered so the ready port is a flop output
            o_in_ready <= next_count != (AW+1)'(DEPTH);
        end
        if (push)
            mem[wr_ptr] <= i_in_data;
    end

    assign o_out_data  = mem[rd_ptr];
    assign o_out_valid = count != '0;
endmodule

// How it works
// - dac takes held register value just before the adc word frame sync rises.
// - a dac advance setting moves the dac load earlier than that point.
// - frame sync pulses, then 16 adc bits shift out msb first.
// - a complete received 16-bit word that is not a control word updates the dac register.
// - the dac output stays unchanged until the load instant arrives.
// - mixed operation: msb clear means dac data, msb set means control.
// - control word with bit 14 set sends the register back out.
module cdlt_codec_dac_load_timing #(
    parameter int SAMPLE_CYCLES = cdlt_pkg::SAMPLE_CYCLES,
    parameter int FIFO_DEPTH    = cdlt_pkg::FIFO_DEPTH
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_reset,
    input  wire logic                          i_clk_link,
    input  wire logic                          i_reset_link,
    input  wire logic [cdlt_pkg::WORD_BITS-1:0] i_adc_data,
    input  wire logic                          i_adc_valid,
    output logic                               o_adc_ready,
    input  wire logic                          i_mixed_operation_select,
    input  wire logic [cdlt_pkg::ADV_BITS-1:0] i_dac_advance,
    output logic [cdlt_pkg::WORD_BITS-1:0]     o_dac_value,
    output logic [cdlt_pkg::WORD_BITS-1:0]     o_control,
    output logic                               o_output_frame_sync,
    output logic                               o_serial_data_out,
    input  wire logic                          i_input_frame_sync,
    input  wire logic                          i_serial_data_in
);
    localparam int W  = cdlt_pkg::WORD_BITS;
    localparam int CW = $clog2(SAMPLE_CYCLES);

    // system domain state
    logic [CW-1:0] samp_cnt, next_samp_cnt;
    logic [W-1:0]  dac_reg, next_dac_reg;
    logic [W-1:0]  next_dac_value, next_control;
    logic [W-1:0]  tx_word, next_tx_word;
    logic          tx_tgl, next_tx_tgl;
    logic          rb_pend, next_rb_pend;
    logic          ack_s1, ack_s2;
    logic          rx_s1, rx_s2, rx_s3;
    logic          fifo_ready;
    logic [W-1:0]  fifo_data;
    logic          fifo_valid;
    logic          frame_now, load_now, tx_busy, rx_new, adc_ready_fifo;
    logic [W-1:0]  rx_word_sys;

    // link domain state
    cdlt_pkg::cdlt_tx_state_t l_state, next_l_state;
    logic [W-1:0]  l_shift, next_l_shift;
    logic [4:0]    l_cnt, next_l_cnt;
    logic          next_l_fs, next_l_sdo;
    logic          l_req_s1, l_req_s2;
    logic          l_ack, next_l_ack;
    logic [W-1:0]  l_rx_sh, next_l_rx_sh;
    logic [W-1:0]  l_rx_word, next_l_rx_word;
    logic [4:0]    l_rx_cnt, next_l_rx_cnt;
    logic          l_rx_tgl, next_l_rx_tgl;

    function automatic logic is_control(input logic [W-1:0] w, input logic mixed);
        return mixed && w[cdlt_pkg::CTRL_FLAG_BIT];
    endfunction

    cdlt_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_reset     (i_reset),
        .i_in_data   (i_adc_data),
        .i_in_valid  (i_adc_valid),
        .o_in_ready  (adc_ready_fifo),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_ready)
    );
    assign o_adc_ready = adc_ready_fifo;

    always_comb
    begin
        int load_pt;
        load_pt = SAMPLE_CYCLES - 2 - int'(i_dac_advance) * cdlt_pkg::ADV_STEP_CYCLES;
        if (load_pt < 0)
            load_pt = 0;
        frame_now      = samp_cnt == CW'(SAMPLE_CYCLES - 1);
        load_now       = samp_cnt == CW'(load_pt);
        tx_busy        = tx_tgl != ack_s2;
        rx_new         = rx_s2 != rx_s3;
        rx_word_sys    = l_rx_word;
        next_samp_cnt  = frame_now ? '0 : samp_cnt + CW'(1);
        next_dac_reg   = dac_reg;
        next_control   = o_control;
        next_rb_pend   = rb_pend;
        next_tx_word   = tx_word;
        next_tx_tgl    = tx_tgl;
        fifo_ready     = 1'b0;
        next_dac_value = load_now ? dac_reg : o_dac_value;
        if (rx_new)
        begin
            if (is_control(rx_word_sys, i_mixed_operation_select))
            begin
                next_control = rx_word_sys;
                if (rx_word_sys[cdlt_pkg::READBACK_BIT])
                    next_rb_pend = 1'b1;
            end
            else
                next_dac_reg = rx_word_sys;
        end
        // adc frames hold the slot; a late host word misses this load
        if (!tx_busy && frame_now)
        begin
            next_tx_word = fifo_valid ? fifo_data : '0;
            fifo_ready   = 1'b1;
            next_tx_tgl  = ~tx_tgl;
        end
        else if (!tx_busy && rb_pend)
        begin
            next_tx_word = {cdlt_pkg::READBACK_TAG, o_control[W-3:0]};
            next_rb_pend = rx_new && rx_word_sys[cdlt_pkg::READBACK_BIT]
                           && is_control(rx_word_sys, i_mixed_operation_select);
            next_tx_tgl  = ~tx_tgl;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            samp_cnt    <= '0;
            dac_reg     <= cdlt_pkg::DAC_RESET;
            o_dac_value <= cdlt_pkg::DAC_RESET;
            o_control   <= cdlt_pkg::CTRL_RESET;
            tx_word     <= '0;
            tx_tgl      <= 1'b0;
            rb_pend     <= 1'b0;
            ack_s1      <= 1'b0;
            ack_s2      <= 1'b0;
            rx_s1       <= 1'b0;
            rx_s2       <= 1'b0;
            rx_s3       <= 1'b0;
        end
        else
        begin
            samp_cnt    <= next_samp_cnt;
            dac_reg     <= next_dac_reg;
            o_dac_value <= next_dac_value;
            o_control   <= next_control;
            tx_word     <= next_tx_word;
            tx_tgl      <= next_tx_tgl;
            rb_pend     <= next_rb_pend;
            ack_s1      <= l_ack;
            ack_s2      <= ack_s1;
            rx_s1       <= l_rx_tgl;
            rx_s2       <= rx_s1;
            rx_s3       <= rx_s2;
        end
    end

    // link side: word from the system side is stable while the toggle differs
    always_comb
    begin
        next_l_state   = l_state;
        next_l_shift   = l_shift;
        next_l_cnt     = l_cnt;
        next_l_fs      = 1'b0;
        next_l_sdo     = 1'b0;
        next_l_ack     = l_ack;
        next_l_rx_sh   = l_rx_sh;
        next_l_rx_word = l_rx_word;
        next_l_rx_cnt  = l_rx_cnt;
        next_l_rx_tgl  = l_rx_tgl;
        case (l_state)
            cdlt_pkg::CDLT_TX_IDLE:
                // level compare against ack: a request raised mid-word waits, not lost
                if (l_req_s2 != l_ack)
                begin
                    next_l_shift = tx_word;
                    next_l_fs    = 1'b1;
                    next_l_cnt   = 5'(W);
                    next_l_ack   = ~l_ack;
                    next_l_state = cdlt_pkg::CDLT_TX_SHIFT;
                end
            cdlt_pkg::CDLT_TX_SHIFT:
            begin
                next_l_sdo   = l_shift[W-1];
                next_l_shift = {l_shift[W-2:0], 1'b0};
                next_l_cnt   = l_cnt - 5'h01;
                if (l_cnt == 5'h01)
                    next_l_state = cdlt_pkg::CDLT_TX_IDLE;
            end
            default:
                next_l_state = cdlt_pkg::CDLT_TX_IDLE;
        endcase
        if (l_rx_cnt != 5'h00)
        begin
            next_l_rx_sh  = {l_rx_sh[W-2:0], i_serial_data_in};
            next_l_rx_cnt = l_rx_cnt - 5'h01;
            if (l_rx_cnt == 5'h01)
            begin
                next_l_rx_word = {l_rx_sh[W-2:0], i_serial_data_in};
                next_l_rx_tgl  = ~l_rx_tgl;
            end
        end
        else if (i_input_frame_sync)
            next_l_rx_cnt = 5'(W);
    end

    always_ff @(posedge i_clk_link)
    begin
        if (i_reset_link)
        begin
            l_state             <= cdlt_pkg::CDLT_TX_IDLE;
            l_shift             <= '0;
            l_cnt               <= '0;
            o_output_frame_sync <= 1'b0;
            o_serial_data_out   <= 1'b0;
            l_req_s1            <= 1'b0;
            l_req_s2            <= 1'b0;
            l_ack               <= 1'b0;
            l_rx_sh             <= '0;
            l_rx_word           <= '0;
            l_rx_cnt            <= '0;
            l_rx_tgl            <= 1'b0;
        end
        else
        begin
            l_state             <= next_l_state;
            l_shift             <= next_l_shift;
            l_cnt               <= next_l_cnt;
            o_output_frame_sync <= next_l_fs;
            o_serial_data_out   <= next_l_sdo;
            l_req_s1            <= tx_tgl;
            l_req_s2            <= l_req_s1;
            l_ack               <= next_l_ack;
            l_rx_sh             <= next_l_rx_sh;
            l_rx_word           <= next_l_rx_word;
            l_rx_cnt            <= next_l_rx_cnt;
            l_rx_tgl            <= next_l_rx_tgl;
        end
    end
endmodule

/* File: cdlt_dsp_model.sv */
// far-end serial port model that sends and receives link words
`timescale 1ns/1ns
module cdlt_dsp_model (
    input  wire logic  i_clk_link,
    input  wire logic  i_sync,
    input  wire logic  i_sdo,
    output logic       o_sync,
    output logic       o_sdi,
    output logic [15:0] o_rx_word,
    output int         o_rx_count
);
    int bits_left = 0;
    initial
    begin
        o_sync = 1'b0;
        o_sdi = 1'b0;
        o_rx_word = 16'h0000;
        o_rx_count = 0;
    end
    // sixteen bits msb first on the edges after the sync edge
    always @(posedge i_clk_link)
    begin
        if (bits_left != 0)
        begin
            o_rx_word <= {o_rx_word[14:0], i_sdo};
            bits_left <= bits_left - 1;
            if (bits_left == 1)
                o_rx_count <= o_rx_count + 1;
        end
        else if (i_sync)
            bits_left <= 16;
    end
    task automatic send(input logic [15:0] w);
        @(posedge i_clk_link);
        #1 o_sync = 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge i_clk_link);
            #1 o_sync = 1'b0;
            o_sdi = w[i];
        end
        @(posedge i_clk_link);
        // released line shows the inverse so a stale bit cannot pass
        #1 o_sdi = ~w[0];
    endtask
endmodule

/* File: cdlt_codec_dac_load_timing_sva.sv */
// port assertions for the codec dac load timing block
`timescale 1ns/1ns
module cdlt_checker #(
    parameter int SAMPLE_CYCLES = cdlt_pkg::SAMPLE_CYCLES,
    parameter int FIFO_DEPTH    = cdlt_pkg::FIFO_DEPTH
) (
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire logic        i_clk_link,
    input wire logic        i_reset_link,
    input wire logic        i_adc_valid,
    input wire logic        o_adc_ready,
    input wire logic        i_mixed_operation_select,
    input wire logic [15:0] o_dac_value,
    input wire logic [15:0] o_control,
    input wire logic        o_output_frame_sync,
    input wire logic        o_serial_data_out
);
    logic [15:0] prev_dac;
    int          gap;
    int          next_gap;
    // saturating count keeps the gap from wrapping on long idle runs
    always_comb
    begin
        next_gap = (gap < SAMPLE_CYCLES) ? gap + 1 : gap;
        if (i_reset)
            next_gap = SAMPLE_CYCLES;
        else if (o_dac_value != prev_dac)
            next_gap = 1;
    end
    always_ff @(posedge i_clk_sys)
    begin
        prev_dac <= o_dac_value;
        gap      <= next_gap;
    end
    sequence s_quiet16;
        !o_output_frame_sync [*8] ##1 !o_output_frame_sync [*8];
    endsequence
    a_sync_spacing: assert property (@(posedge i_clk_link) disable iff (i_reset_link)
        o_output_frame_sync |=> s_quiet16) else $error("frame sync inside a word");
    a_sdo_lead: assert property (@(posedge i_clk_link) disable iff (i_reset_link)
        o_output_frame_sync |-> !o_serial_data_out) else $error("data high with sync");
    a_sdo_tail: assert property (@(posedge i_clk_link) disable iff (i_reset_link)
        o_output_frame_sync |-> ##17 !o_serial_data_out) else $error("data after word");
    a_link_reset: assert property (@(posedge i_clk_link) disable iff (i_reset_link)
        $fell(i_reset_link) |-> !o_output_frame_sync && !o_serial_data_out)
        else $error("link outputs after reset");
    a_sys_reset: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(i_reset) |-> o_adc_ready && o_dac_value == 16'h0000 && o_control == 16'h0000)
        else $error("sys outputs after reset");
    a_ready_cause: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $fell(o_adc_ready) |-> $past(i_adc_valid)) else $error("ready fell without push");
    a_ctrl_mixed: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $changed(o_control) |-> o_control[15] && i_mixed_operation_select)
        else $error("control word outside mixed mode");
    a_dac_gap: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_dac_value != prev_dac |-> gap >= SAMPLE_CYCLES / 2) else $error("dac moved twice");
endmodule
bind cdlt_codec_dac_load_timing cdlt_checker #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .FIFO_DEPTH(FIFO_DEPTH)
) chk (
    .i_clk_sys, .i_reset, .i_clk_link, .i_reset_link, .i_adc_valid, .o_adc_ready,
    .i_mixed_operation_select, .o_dac_value, .o_control, .o_output_frame_sync,
    .o_serial_data_out
);

/* File: cdlt_codec_dac_load_timing_bench.sv */
// self-checking bench for the codec dac load timing block
`timescale 1ns/1ns
module cdlt_codec_dac_load_timing_bench;
    localparam int SC = 200;
    logic        i_clk_sys                = 1'b0;
    logic        i_clk_link               = 1'b0;
    logic        i_reset                  = 1'b1;
    logic        i_reset_link             = 1'b1;
    logic [15:0] i_adc_data               = 16'h0000;
    logic        i_adc_valid              = 1'b0;
    logic        i_mixed_operation_select = 1'b0;
    logic [3:0]  i_dac_advance            = 4'h0;
    logic        o_adc_ready;
    logic [15:0] o_dac_value;
    logic [15:0] o_control;
    logic        o_output_frame_sync;
    logic        o_serial_data_out;
    logic        i_input_frame_sync;
    logic        i_serial_data_in;
    logic [15:0] rx_word;
    int          rx_count;
    int          failures        = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    cdlt_codec_dac_load_timing #(.SAMPLE_CYCLES(SC), .FIFO_DEPTH(cdlt_pkg::FIFO_DEPTH)) DUT (
        .i_clk_sys, .i_reset, .i_clk_link, .i_reset_link, .i_adc_data, .i_adc_valid,
        .o_adc_ready, .i_mixed_operation_select, .i_dac_advance, .o_dac_value, .o_control,
        .o_output_frame_sync, .o_serial_data_out, .i_input_frame_sync, .i_serial_data_in
    );
    cdlt_dsp_model dsp (
        .i_clk_link, .i_sync(o_output_frame_sync), .i_sdo(o_serial_data_out),
        .o_sync(i_input_frame_sync), .o_sdi(i_serial_data_in), .o_rx_word(rx_word),
        .o_rx_count(rx_count)
    );
    initial
        forever #20 i_clk_sys = ~i_clk_sys;
    initial
    begin
        #1;
        forever #3 i_clk_link = ~i_clk_link;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("%0d checks, %0d failures", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            failures++;
            print_verdict();
        end
    end
    // returns just after the sys edge that follows a completed word
    task automatic wait_rx();
        int n;
        n = rx_count;
        for (int k = 0; k < 2 * SC && rx_count == n; k++)
            @(posedge i_clk_sys);
        #1;
    endtask
    task automatic test_fifo();
        int n;
        n = 0;
        wait_rx();
        i_adc_valid = 1'b1;
        while (o_adc_ready === 1'b1 && n < 20)
        begin
            i_adc_data = 16'h1000 + 16'(n);
            @(posedge i_clk_sys);
            #1 n++;
        end
        i_adc_valid = 1'b0;
        check(16'(n), 16'(cdlt_pkg::FIFO_DEPTH));
        for (int i = 0; i <= 16; i++)
        begin
            wait_rx();
            check(rx_word, (i < 16) ? 16'h1000 + 16'(i) : 16'h0000);
        end
        $display("fifo test done");
    endtask
    task automatic test_load(input logic [3:0] adv, input logic [15:0] w);
        logic [15:0] old;
        time         tl;
        time         ts;
        wait_rx();
        i_dac_advance = adv;
        old = o_dac_value;
        tl = 0;
        ts = 0;
        dsp.send(w);
        repeat (6) @(posedge i_clk_sys);
        #1 check(o_dac_value, old);
        for (int k = 0; k < 2 * SC && tl == 0; k++)
        begin
            @(posedge i_clk_sys);
            #1 if (o_dac_value !== old) tl = $time;
        end
        check(o_dac_value, w);
        for (int k = 0; k < 2000 && ts == 0; k++)
        begin
            @(posedge i_clk_link);
            #1 if (o_output_frame_sync === 1'b1) ts = $time;
        end
        check(16'((ts - tl) / cdlt_pkg::CLK_SYS_NS),
              16'(1 + int'(adv) * cdlt_pkg::ADV_STEP_CYCLES));
        $display("load test done");
    endtask
    task automatic test_mixed();
        logic [15:0] dac;
        wait_rx();
        i_mixed_operation_select = 1'b1;
        dac = o_dac_value;
        dsp.send(16'h8123);
        wait_rx();
        check(rx_word, 16'h0000);
        check(o_control, 16'h8123);
        check(o_dac_value, dac);
        dsp.send(16'hC0A5);
        wait_rx();
        check(rx_word, 16'hC0A5);
        check(o_control, 16'hC0A5);
        $display("mixed test done");
    endtask
    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        i_reset_link = 1'b0;
        test_fifo();
        test_load(4'h0, 16'h9234);
        test_load(4'h1, 16'h0456);
        test_load(4'h3, 16'h7ABC);
        test_mixed();
        print_verdict();
    end
endmodule
